// file: hw/motor_start_supervision.sv
// Motor status tracker, reverse sequence stage and stall stage
`timescale 1ns/1ns
`default_nettype none
`include "motor_supervision_defines.svh"

module motor_start_supervision
    import motor_supervision_pkg::*;
#(
    parameter int TickCycles = `MS_IN_NS / `CLOCK_PERIOD_NS,
    parameter int ForceTimeoutMs = `FORCE_TIMEOUT_MS
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire motor_supervision_pkg::measure_t measure,
    input wire logic buttonPress,
    input wire logic [7:0] address,
    input wire logic [31:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [31:0] readData,
    output motor_supervision_pkg::matrix_t matrix
);
    import motor_supervision_pkg::*;

    reset_state_t r;
    state_t s;
    state_t next_s;
    logic rstSync;
    logic tick;
    logic revDone;
    logic stallDone;
    logic [15:0] revPct;
    logic [15:0] stallPct;
    logic [31:0] stallWeight;
    logic [47:0] stallTarget;
    logic forceOn;

    function automatic logic [15:0] satInc(input logic [15:0] v);
        begin
            return (v == `COUNT_MAX) ? v : v + 16'h1;
        end
    endfunction

    function automatic logic [31:0] square(input logic [15:0] v);
        begin
            return 32'(v) * 32'(v);
        end
    endfunction

    function automatic logic [31:0] pack2(input logic [15:0] hi, input logic [15:0] lo);
        begin
            return {hi, lo};
        end
    endfunction

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= '{rstMeta: 1'b1, rstSync: r.rstMeta};
    end
    assign rstSync = r.rstSync;

    assign tick = (s.prescale == 18'(TickCycles - 1));
    assign forceOn = s.control[`CTRL_FORCE];

    // Stall operate time: definite, or inverse by squared current ratio
    always_comb
    begin
        if (s.control[`CTRL_INVERSE])
        begin
            stallWeight = square(measure.avgCurrent);
            stallTarget = 48'(s.allowedTime) * 48'(square(s.ratedStart));
        end
        else
        begin
            stallWeight = 32'h1;
            stallTarget = 48'(s.definiteTime);
        end
    end

    stage_timer revTimer (
        .clock(clock),
        .rstSync(rstSync),
        .tick(tick),
        .run(s.revStart),
        .weight(32'h1),
        .target(`REV_DELAY_MS),
        .done(revDone),
        .elapsedPct(revPct)
    );

    stage_timer stallTimer (
        .clock(clock),
        .rstSync(rstSync),
        .tick(tick),
        .run(s.stallStart),
        .weight(stallWeight),
        .target(stallTarget),
        .done(stallDone),
        .elapsedPct(stallPct)
    );

    always_comb
    begin
        logic low;
        logic inRun;
        logic detect;
        low = 1'b0;
        inRun = 1'b0;
        detect = 1'b0;
        next_s = s;
        next_s.rdata = 32'h0;
        next_s.prescale = tick ? 18'h0 : s.prescale + 18'h1;
        if (tick)
            next_s.nowMs = s.nowMs + 32'h1;

        low = measure.avgCurrent < `LOW_LIMIT_PCT;
        inRun = measure.avgCurrent >= `RUN_LOW_PCT && measure.avgCurrent <= `RUN_HIGH_PCT;
        // Rise above threshold shortly after a low period
        detect = !low && measure.avgCurrent > s.startThr
            && s.sinceLowMs <= `START_WINDOW_MS;
        if (low)
            next_s.sinceLowMs = 16'h0;
        else if (tick)
            next_s.sinceLowMs = satInc(s.sinceLowMs);

        // Status tracker
        unique case (s.status)
            STOPPED:
            begin
                if (detect && s.stoppedMs >= `STOP_MIN_MS)
                    next_s.status = STARTING;
                else if (inRun && s.sinceLowMs > `START_WINDOW_MS)
                    next_s.status = RUNNING;
            end
            STARTING:
            begin
                if (low)
                    next_s.status = STOPPED;
                else if (inRun)
                    next_s.status = RUNNING;
            end
            RUNNING:
            begin
                if (low)
                    next_s.status = STOPPED;
            end
            default:
                next_s.status = STOPPED;
        endcase
        // Stopped time kept through the rise, so a ramp inside the window counts
        if (s.status != STOPPED || (low && s.sinceLowMs != 16'h0))
            next_s.stoppedMs = 16'h0;
        else if (low && tick)
            next_s.stoppedMs = satInc(s.stoppedMs);

        // Stall stage
        if (detect)
            next_s.stallArmed = 1'b1;
        else if (measure.avgCurrent < `RUN_HIGH_PCT)
            next_s.stallArmed = 1'b0;
        next_s.stallStart = next_s.stallArmed && next_s.status == STARTING;
        next_s.stallTrip = next_s.stallStart && s.stallStart && stallDone;

        // Reverse sequence stage
        next_s.revStart = next_s.status == STARTING
            && measure.seqRatio > `REV_RATIO_PCT
            && measure.avgCurrent > `REV_CURRENT_PCT;
        next_s.revTrip = next_s.revStart && s.revStart && revDone;

        // Force flag idle timeout
        if (buttonPress || !forceOn)
            next_s.forceIdleMs = 19'h0;
        else if (tick)
            next_s.forceIdleMs = s.forceIdleMs + 19'h1;
        if (forceOn && s.forceIdleMs >= 19'(ForceTimeoutMs))
        begin
            next_s.control[`CTRL_FORCE] = 1'b0;
            next_s.forceIdleMs = 19'h0;
        end

        // Register writes
        if (writeStrobe)
        begin
            unique case (address)
                `ADDR_CONTROL:
                begin
                    next_s.control = writeData[3:0];
                    next_s.forceIdleMs = 19'h0;
                end
                `ADDR_START_THR: next_s.startThr = writeData[15:0];
                `ADDR_RATED_START: next_s.ratedStart = writeData[15:0];
                `ADDR_ALLOWED_TIME: next_s.allowedTime = writeData[15:0];
                `ADDR_DEFINITE_TIME: next_s.definiteTime = writeData[15:0];
                `ADDR_REV_COUNTS:
                begin
                    next_s.revStartCnt = 16'h0;
                    next_s.revTripCnt = 16'h0;
                    next_s.revMaxRatio = 16'h0;
                end
                `ADDR_STALL_COUNTS:
                begin
                    next_s.stallStartCnt = 16'h0;
                    next_s.stallTripCnt = 16'h0;
                    next_s.stallMaxCurrent = 16'h0;
                end
                default:
                    next_s.rdata = 32'h0;
            endcase
        end

        // Counters and fault records, event wins over clear
        if (next_s.revStart && !s.revStart)
            next_s.revStartCnt = satInc(next_s.revStartCnt);
        if (next_s.revTrip && !s.revTrip)
            next_s.revTripCnt = satInc(next_s.revTripCnt);
        if (next_s.revStart && measure.seqRatio > next_s.revMaxRatio)
            next_s.revMaxRatio = measure.seqRatio;
        if (next_s.stallStart && !s.stallStart)
        begin
            next_s.stallStartCnt = satInc(next_s.stallStartCnt);
            next_s.stallStartTime = s.nowMs;
        end
        if (next_s.stallTrip && !s.stallTrip)
        begin
            next_s.stallTripCnt = satInc(next_s.stallTripCnt);
            next_s.stallTripTime = s.nowMs;
        end
        if (next_s.stallStart && measure.avgCurrent > next_s.stallMaxCurrent)
            next_s.stallMaxCurrent = measure.avgCurrent;

        // Register reads, data valid the next cycle only
        if (readStrobe)
        begin
            unique case (address)
                `ADDR_CONTROL: next_s.rdata = 32'(s.control);
                `ADDR_START_THR: next_s.rdata = 32'(s.startThr);
                `ADDR_RATED_START: next_s.rdata = 32'(s.ratedStart);
                `ADDR_ALLOWED_TIME: next_s.rdata = 32'(s.allowedTime);
                `ADDR_DEFINITE_TIME: next_s.rdata = 32'(s.definiteTime);
                `ADDR_STATUS:
                    next_s.rdata = 32'({forceOn, s.stallTrip, s.stallStart,
                        s.revTrip, s.revStart, s.status});
                `ADDR_REV_COUNTS: next_s.rdata = pack2(s.revTripCnt, s.revStartCnt);
                `ADDR_STALL_COUNTS: next_s.rdata = pack2(s.stallTripCnt, s.stallStartCnt);
                `ADDR_REV_FAULT: next_s.rdata = pack2(revPct, s.revMaxRatio);
                `ADDR_STALL_FAULT:
                    next_s.rdata = pack2(stallPct, s.stallMaxCurrent);
                `ADDR_STALL_START_TIME: next_s.rdata = s.stallStartTime;
                `ADDR_STALL_TRIP_TIME: next_s.rdata = s.stallTripTime;
                default: next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            s <= '0;
            s.status <= STOPPED;
            s.sinceLowMs <= `COUNT_MAX;
            s.startThr <= `START_THR_RESET;
            s.ratedStart <= `RATED_START_RESET;
            s.allowedTime <= `ALLOWED_TIME_RESET;
            s.definiteTime <= `DEFINITE_TIME_RESET;
        end
        else
            s <= next_s;
    end

    // Matrix outputs, forced values only under the force flag
    assign readData = s.rdata;
    assign matrix.running = s.status == RUNNING;
    assign matrix.starting = s.status == STARTING;
    assign matrix.lockedRotorBlock = s.status == STARTING;
    assign matrix.revStart = s.revStart || (forceOn && s.control[`CTRL_FORCED_START]);
    assign matrix.revTrip = s.revTrip || (forceOn && s.control[`CTRL_FORCED_TRIP]);
    assign matrix.stallStart = s.stallStart || (forceOn && s.control[`CTRL_FORCED_START]);
    assign matrix.stallTrip = s.stallTrip || (forceOn && s.control[`CTRL_FORCED_TRIP]);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync);

    a_stopped_on_low: assert property (
        measure.avgCurrent < `LOW_LIMIT_PCT |=> s.status == STOPPED)
        else $error("status not stopped under low current");
    a_starting_entry: assert property (
        s.status == STOPPED ##1 s.status == STARTING
        |-> $past(s.stoppedMs) >= `STOP_MIN_MS)
        else $error("starting entered without stopped time");
    a_running_range: assert property (
        s.status != RUNNING ##1 s.status == RUNNING
        |-> $past(measure.avgCurrent) >= `RUN_LOW_PCT
        && $past(measure.avgCurrent) <= `RUN_HIGH_PCT)
        else $error("running entered outside current range");
    a_stall_in_start: assert property (s.stallStart |-> s.status == STARTING)
        else $error("stall start outside starting status");
    a_stall_release: assert property (
        s.stallStart && measure.avgCurrent < `RUN_HIGH_PCT && !writeStrobe
        |=> !s.stallStart)
        else $error("stall stage did not release");
    a_rev_condition: assert property (
        s.revStart |-> $past(measure.seqRatio) > `REV_RATIO_PCT
        && $past(measure.avgCurrent) > `REV_CURRENT_PCT)
        else $error("reverse start without condition");
    a_rev_trip_start: assert property (s.revTrip |-> s.revStart && revPct == `PCT_FULL)
        else $error("reverse trip without start");
    a_rev_trip_count: assert property (
        $rose(s.revTrip) |-> s.revTripCnt == satInc($past(s.revTripCnt))
        || $past(writeStrobe))
        else $error("reverse trip count not advanced");
    a_definite_target: assert property (
        !s.control[`CTRL_INVERSE] |-> stallTarget == 48'(s.definiteTime)
        && stallWeight == 32'h1
        && (!s.stallTrip || stallPct == `PCT_FULL))
        else $error("definite stall target wrong");
    a_force_timeout: assert property (
        forceOn && s.forceIdleMs >= 19'(ForceTimeoutMs) && !writeStrobe
        |=> !forceOn)
        else $error("force flag outlived its timeout");
    a_block_lr: assert property (matrix.lockedRotorBlock == matrix.starting)
        else $error("locked rotor block differs from starting");

    c_motor_start: cover property (s.status == STOPPED ##1 s.status == STARTING);
    c_soft_start: cover property (s.status == STOPPED ##1 s.status == RUNNING);
    c_stall_trip: cover property ($rose(s.stallTrip));
    c_rev_trip: cover property ($rose(s.revTrip));
endmodule
`default_nettype wire

// file: hw/motor_supervision_defines.svh
// Constants of the motor start supervision block
`ifndef MOTOR_SUPERVISION_DEFINES_SVH
`define MOTOR_SUPERVISION_DEFINES_SVH

`define CLOCK_PERIOD_NS 4
`define MS_IN_NS 1000000
`define FORCE_TIMEOUT_MIN 5
`define FORCE_TIMEOUT_MS (`FORCE_TIMEOUT_MIN * 60 * 1000)

`define LOW_LIMIT_PCT 16'h000a
`define RUN_LOW_PCT 16'h0014
`define RUN_HIGH_PCT 16'h0078
`define REV_RATIO_PCT 16'h0050
`define REV_CURRENT_PCT 16'h0014
`define REV_DELAY_MS 48'h64
`define START_WINDOW_MS 16'h00c8
`define STOP_MIN_MS 16'h01f4
`define PCT_FULL 16'h0064
`define COUNT_MAX 16'hffff

`define START_THR_RESET 16'h0258
`define RATED_START_RESET 16'h0258
`define ALLOWED_TIME_RESET 16'h2710
`define DEFINITE_TIME_RESET 16'h2710

`define ADDR_CONTROL 8'h00
`define ADDR_START_THR 8'h04
`define ADDR_RATED_START 8'h08
`define ADDR_ALLOWED_TIME 8'h0c
`define ADDR_DEFINITE_TIME 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_REV_COUNTS 8'h18
`define ADDR_STALL_COUNTS 8'h1c
`define ADDR_REV_FAULT 8'h20
`define ADDR_STALL_FAULT 8'h24
`define ADDR_STALL_START_TIME 8'h28
`define ADDR_STALL_TRIP_TIME 8'h2c

`define CTRL_INVERSE 0
`define CTRL_FORCE 1
`define CTRL_FORCED_START 2
`define CTRL_FORCED_TRIP 3

`endif

// file: hw/motor_supervision_pkg.sv
// Types of the motor start supervision block
package motor_supervision_pkg;

    typedef enum logic [1:0] {STOPPED, STARTING, RUNNING} motor_state_t;

    typedef struct packed {
        logic [15:0] avgCurrent;
        logic [15:0] seqRatio;
    } measure_t;

    typedef struct packed {
        logic running;
        logic starting;
        logic revStart;
        logic revTrip;
        logic stallStart;
        logic stallTrip;
        logic lockedRotorBlock;
    } matrix_t;

    typedef struct packed {
        logic [47:0] acc;
        logic done;
        logic [15:0] pct;
    } timer_state_t;

    typedef struct packed {
        logic rstMeta;
        logic rstSync;
    } reset_state_t;

    typedef struct packed {
        logic [17:0] prescale;
        logic [31:0] nowMs;
        motor_state_t status;
        logic [15:0] sinceLowMs;
        logic [15:0] stoppedMs;
        logic stallArmed;
        logic stallStart;
        logic stallTrip;
        logic revStart;
        logic revTrip;
        logic [3:0] control;
        logic [18:0] forceIdleMs;
        logic [15:0] startThr;
        logic [15:0] ratedStart;
        logic [15:0] allowedTime;
        logic [15:0] definiteTime;
        logic [15:0] revStartCnt;
        logic [15:0] revTripCnt;
        logic [15:0] stallStartCnt;
        logic [15:0] stallTripCnt;
        logic [15:0] revMaxRatio;
        logic [15:0] stallMaxCurrent;
        logic [31:0] stallStartTime;
        logic [31:0] stallTripTime;
        logic [31:0] rdata;
    } state_t;

endpackage

// file: hw/stage_timer.sv
// Weighted operate timer with elapsed percentage
`timescale 1ns/1ns
`default_nettype none
`include "motor_supervision_defines.svh"

module stage_timer
    import motor_supervision_pkg::*;
(
    input wire logic clock,
    input wire logic rstSync,
    input wire logic tick,
    input wire logic run,
    input wire logic [31:0] weight,
    input wire logic [47:0] target,
    output logic done,
    output logic [15:0] elapsedPct
);
    timer_state_t s;
    timer_state_t next_s;

    function automatic logic [15:0] percentOf(input logic [47:0] num, input logic [47:0] den);
        logic [55:0] q;
        begin
            q = 56'h0;
            if (den == 48'h0)
                return `PCT_FULL;
            q = (56'(num) * 56'(`PCT_FULL)) / 56'(den);
            if (q > 56'(`PCT_FULL))
                return `PCT_FULL;
            return q[15:0];
        end
    endfunction

    always_comb
    begin
        next_s = s;
        if (!run)
            next_s.acc = 48'h0;
        else if (tick && !s.done)
            next_s.acc = s.acc + 48'(weight);
        next_s.done = run && (next_s.acc >= target);
        next_s.pct = run ? percentOf(next_s.acc, target) : 16'h0;
    end

    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            s <= '0;
        else
            s <= next_s;
    end

    assign done = s.done;
    assign elapsedPct = s.pct;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync);

    a_done_full_pct: assert property (done |-> elapsedPct == `PCT_FULL)
        else $error("timer done without full elapsed percentage");
    a_idle_clears: assert property (!run |=> !done && elapsedPct == 16'h0)
        else $error("timer not cleared when idle");
endmodule
`default_nettype wire

// file: tb/current_source.sv
// Phase current measurement model feeding the supervision block
`timescale 1ns/1ns
`default_nettype none

module current_source
(
    input wire logic clock,
    input wire logic [15:0] level,
    input wire logic [15:0] ratio,
    input wire logic ramp,
    output var motor_supervision_pkg::measure_t measure
);
    import motor_supervision_pkg::*;

    // Step change for direct starts, slow climb for soft starters
    always_ff @(posedge clock)
    begin
        measure.seqRatio <= ratio;
        if (!ramp)
        begin
            measure.avgCurrent <= level;
        end
        else if (measure.avgCurrent < level)
        begin
            measure.avgCurrent <= measure.avgCurrent + 16'h0001;
        end
        else
        begin
            measure.avgCurrent <= level;
        end
    end
endmodule

`default_nettype wire

// file: tb/motor_start_supervision_test.sv
// Bench for the motor start supervision block
`timescale 1ns/1ns
`default_nettype none
`include "motor_supervision_defines.svh"

module motor_start_supervision_test;
    import motor_supervision_pkg::*;

    logic clock;
    logic rst_n;
    logic buttonPress;
    logic [7:0] address;
    logic [31:0] writeData;
    logic writeStrobe;
    logic readStrobe;
    logic [31:0] readData;
    matrix_t matrix;
    measure_t measure;
    logic [15:0] level;
    logic [15:0] ratio;
    logic ramp;
    logic sawStart;
    logic watchStart;
    int checks;
    int mismatches;

    current_source source (.clock(clock), .level(level), .ratio(ratio), .ramp(ramp),
        .measure(measure));

    motor_start_supervision #(.TickCycles(10), .ForceTimeoutMs(20)) DUT (
        .clock(clock), .rst_n(rst_n), .measure(measure), .buttonPress(buttonPress),
        .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData), .matrix(matrix));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (!watchStart)
        begin
            sawStart <= 1'b0;
        end
        else if (matrix.starting === 1'b1)
        begin
            sawStart <= 1'b1;
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        chk(name, exp, readData);
        @(posedge clock);
        #1;
        chk("readData idle", 32'h0, readData);
    endtask

    task automatic ms(input int n);
        repeat (n * 10) @(posedge clock);
        #1;
    endtask

    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask

    initial
    begin
        repeat (100000) @(posedge clock);
        mismatches++;
        close_out();
    end

    initial
    begin
        checks = 0;
        mismatches = 0;
        watchStart = 1'b0;
        rst_n = 1'b0;
        buttonPress = 1'b0;
        address = 8'h00;
        writeData = 32'h0;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        level = 16'h0000;
        ratio = 16'h0000;
        ramp = 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`ADDR_START_THR, 32'h258, "startThr");
        rd(`ADDR_RATED_START, 32'h258, "ratedStart");
        rd(`ADDR_STATUS, 32'h0, "status");
        $display("test reset values done");

        wr(`ADDR_DEFINITE_TIME, 32'h12c);
        ms(600);
        level <= 16'h02bc;
        ratio <= 16'h005a;
        settle();
        chk("starting", 1, matrix.starting);
        chk("lockedRotorBlock", 1, matrix.lockedRotorBlock);
        chk("revStart", 1, matrix.revStart);
        ms(98);
        chk("revTrip early", 0, matrix.revTrip);
        ms(4);
        chk("revTrip", 1, matrix.revTrip);
        ms(192);
        chk("stallTrip early", 0, matrix.stallTrip);
        chk("starting held", 1, matrix.starting);
        ms(10);
        chk("stallTrip", 1, matrix.stallTrip);
        rd(`ADDR_REV_FAULT, 32'h0064005a, "revFault");
        rd(`ADDR_STALL_FAULT, 32'h006402bc, "stallFault");
        level <= 16'h0064;
        settle();
        chk("running", 1, matrix.running);
        chk("stallStart released", 0, matrix.stallStart);
        chk("starting left", 0, matrix.starting);
        rd(`ADDR_REV_COUNTS, 32'h00010001, "revCounts");
        rd(`ADDR_STALL_COUNTS, 32'h00010001, "stallCounts");
        level <= 16'h0000;
        settle();
        chk("stopped", 0, {matrix.running, matrix.starting});
        $display("test direct start done");

        wr(`ADDR_CONTROL, 32'h1);
        wr(`ADDR_START_THR, 32'hc8);
        wr(`ADDR_ALLOWED_TIME, 32'h64);
        wr(`ADDR_STALL_COUNTS, 32'h0);
        ratio <= 16'h0000;
        ms(600);
        level <= 16'h012c;
        settle();
        chk("inverse starting", 1, matrix.starting);
        ms(388);
        chk("inverse early", 0, matrix.stallTrip);
        ms(20);
        chk("inverse trip", 1, matrix.stallTrip);
        rd(`ADDR_STALL_COUNTS, 32'h00010001, "stallCounts after clear");
        rd(`ADDR_STALL_FAULT, 32'h0064012c, "stallFault inverse");
        level <= 16'h0064;
        settle();
        level <= 16'h0000;
        ms(600);
        $display("test inverse stall done");

        watchStart <= 1'b1;
        ramp <= 1'b1;
        level <= 16'h0064;
        ms(300);
        chk("soft running", 1, matrix.running);
        chk("soft never starting", 0, sawStart);
        $display("test soft start done");

        ramp <= 1'b0;
        wr(`ADDR_CONTROL, 32'he);
        settle();
        chk("forced revStart", 1, matrix.revStart);
        chk("forced stallStart", 1, matrix.stallStart);
        chk("forced revTrip", 1, matrix.revTrip);
        chk("forced stallTrip", 1, matrix.stallTrip);
        ms(15);
        @(posedge clock);
        buttonPress <= 1'b1;
        @(posedge clock);
        buttonPress <= 1'b0;
        ms(15);
        chk("force kept", 1, matrix.revTrip);
        ms(10);
        chk("force cleared", 0, matrix.revTrip);
        rd(`ADDR_STATUS, 32'h2, "status");
        wr(`ADDR_REV_COUNTS, 32'h0);
        rd(`ADDR_REV_COUNTS, 32'h0, "revCounts cleared");
        $display("test force flag done");
        close_out();
    end
endmodule

`default_nettype wire
